// ---- shared/gprf_pkg.sv ----
// Shared constants and types for the register file with lazy context save
package gprf_pkg;
   localparam int unsigned NUM_REGS   = 64;
   localparam int unsigned IDX_W      = 6;
   localparam int unsigned DATA_W     = 64;
   localparam int unsigned INSTR_W    = 32;
   // Operand field positions in the instruction word
   localparam int unsigned DST_LSB    = 0;
   localparam int unsigned SRC1_LSB   = 6;
   localparam int unsigned SRC2_LSB   = 12;
   localparam int unsigned OPC_LSB    = 24;
   localparam int unsigned OPC_W      = 8;
   localparam logic [7:0]  OPC_COPY   = 8'h01;
   localparam logic [5:0]  ZERO_IDX   = 6'h00;
   localparam logic [63:0] REG_RESET  = 64'h0;
   localparam logic [63:0] SAVED_ALL  = 64'hffff_ffff_ffff_ffff;

   typedef enum logic [0:0] {
      GPRF_IDLE   = 1'b0,
      GPRF_SAVING = 1'b1
   } gprf_save_state_t;
endpackage

// ---- logic/gprf_find_first.sv ----
// Find-first-clear search over the saved flags
`timescale 1ns/1ps
module gprf_find_first #(
   parameter int unsigned N = 64,
   parameter int unsigned W = 6
) (
   input  wire logic [N-1:0] saved_flags,
   output logic      [W-1:0] first_idx,
   output logic              any_unsaved
);
   // Lowest index wins; register zero is never considered
   always_comb begin
      first_idx   = '0;
      any_unsaved = 1'b0;
      for (int i = N - 1; i >= 1; i--) begin
         if (!saved_flags[i]) begin
            first_idx   = W'(i);
            any_unsaved = 1'b1;
         end
      end
   end
endmodule

// ---- logic/gprf_regfile.sv ----
// Register file with scoreboard and lazy save of the previous thread
//
// What this block does
// - Sixty-four registers, each usable as operand source or result destination.
// - Register zero reads zero; writes to it are discarded.
// - Copy from register zero clears destination without waiting on its sources; a pending or unsaved destination still stalls it.
// - Operand selection takes fixed 32-bit instruction words only.
// - Scoreboard stalls issue when an operand is not yet ready.
// - Context switch makes hardware save old registers interleaved with new code.
// - Each old register saved no later than its first new write.
// - One saved flag per register; next save chosen by find-first.
// - Saving is invisible; results never depend on save progress.
`timescale 1ns/1ps
module gprf_regfile #(
   parameter int unsigned NUM_REGS = gprf_pkg::NUM_REGS,
   parameter int unsigned DATA_W   = gprf_pkg::DATA_W
) (
   input  wire logic                         clock,
   input  wire logic                         rst_b,
   // Issue side
   input  wire logic                         issue_valid,
   input  wire logic [gprf_pkg::INSTR_W-1:0] issue_instr,
   output logic                              issue_stall_q,
   output logic                              issue_accept_q,
   output logic [DATA_W-1:0]                 opa_data_q,
   output logic [DATA_W-1:0]                 opb_data_q,
   output logic                              copy_done_q,
   // Execution completion
   input  wire logic                         wb_valid,
   input  wire logic [gprf_pkg::IDX_W-1:0]   wb_idx,
   input  wire logic [DATA_W-1:0]            wb_data,
   output logic                              wb_stall_q,
   // Context switch and save store path
   input  wire logic                         ctx_switch,
   input  wire logic                         store_ready,
   output logic                              save_valid_q,
   output logic [gprf_pkg::IDX_W-1:0]        save_idx_q,
   output logic [DATA_W-1:0]                 save_data_q,
   output logic                              save_busy_q
);
   localparam int unsigned IW = gprf_pkg::IDX_W;

   logic [DATA_W-1:0]   regs_q [NUM_REGS];
   logic [NUM_REGS-1:0] pending_q;
   logic [NUM_REGS-1:0] saved_q;
   gprf_pkg::gprf_save_state_t state_q;

   function automatic logic [IW-1:0] field(input logic [gprf_pkg::INSTR_W-1:0] ins,
                                           input int unsigned lsb);
      field = ins[lsb +: IW];
   endfunction

   // Zero index reads as zero without touching the array
   function automatic logic [DATA_W-1:0] rd(input logic [IW-1:0] idx);
      rd = (idx == gprf_pkg::ZERO_IDX) ? '0 : regs_q[idx];
   endfunction

   logic [IW-1:0] dst;
   logic [IW-1:0] src1;
   logic [IW-1:0] src2;
   logic          is_copy;
   logic          copy_zero;
   logic          src_busy;
   logic          dst_busy;
   logic          dst_unsaved;
   logic          stall;
   logic          accept;
   logic [IW-1:0] ff_idx;
   logic          ff_any;
   logic          save_fire;
   logic          wb_unsaved;
   logic          wb_ok;

   // Operand fields come only from the 32-bit word
   assign dst       = field(issue_instr, gprf_pkg::DST_LSB);
   assign src1      = field(issue_instr, gprf_pkg::SRC1_LSB);
   assign src2      = field(issue_instr, gprf_pkg::SRC2_LSB);
   assign is_copy   = issue_instr[gprf_pkg::OPC_LSB +: gprf_pkg::OPC_W] == gprf_pkg::OPC_COPY;
   assign copy_zero = is_copy && (src1 == gprf_pkg::ZERO_IDX);

   // Copy ignores second source; zero source never pending
   assign src_busy  = !copy_zero &&
                      (pending_q[src1] || (!is_copy && pending_q[src2]));
   assign dst_busy  = (dst != gprf_pkg::ZERO_IDX) && pending_q[dst];
   assign dst_unsaved = (dst != gprf_pkg::ZERO_IDX) && !saved_q[dst]
                        && !(save_fire && save_idx_q == dst);
   assign stall     = issue_valid && (src_busy || dst_busy || dst_unsaved);
   assign accept    = issue_valid && !stall;

   gprf_find_first #(
      .N (NUM_REGS),
      .W (IW)
   ) u_find (
      .saved_flags (saved_q),
      .first_idx   (ff_idx),
      .any_unsaved (ff_any)
   );

   assign save_fire  = save_valid_q && store_ready;
   // A write-back may land only once its old value is out
   assign wb_unsaved = !saved_q[wb_idx] && !(save_fire && save_idx_q == wb_idx);
   assign wb_ok      = wb_valid && (wb_idx != gprf_pkg::ZERO_IDX) && !wb_unsaved;

   // Array write: copy-zero result or execution write-back
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= gprf_pkg::REG_RESET;
         end
      end else begin
         if (wb_ok) begin
            regs_q[wb_idx] <= wb_data;
         end
         if (accept && copy_zero && dst != gprf_pkg::ZERO_IDX) begin
            regs_q[dst] <= '0;
         end
      end
   end

   // Scoreboard: set at issue, cleared at write-back; set wins
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pending_q <= '0;
      end else begin
         if (wb_ok) begin
            pending_q[wb_idx] <= 1'b0;
         end
         if (accept && !copy_zero && dst != gprf_pkg::ZERO_IDX) begin
            pending_q[dst] <= 1'b1;
         end
      end
   end

   // Saved flags: cleared on switch except register zero, set per save issued
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         saved_q <= gprf_pkg::SAVED_ALL;
      end else if (ctx_switch) begin
         // A new switch outranks a store in flight; that store is the old context's
         saved_q    <= '0;
         saved_q[0] <= 1'b1;
      end else if (save_fire) begin
         saved_q[save_idx_q] <= 1'b1;
      end
   end

   // Save engine: offers the first unsaved register to the store path
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q      <= gprf_pkg::GPRF_IDLE;
         save_valid_q <= 1'b0;
         save_idx_q   <= '0;
         save_data_q  <= '0;
      end else begin
         case (state_q)
            gprf_pkg::GPRF_IDLE: begin
               save_valid_q <= 1'b0;
               if (ctx_switch) begin
                  state_q <= gprf_pkg::GPRF_SAVING;
               end
            end
            gprf_pkg::GPRF_SAVING: begin
               // Hold the offer stable until the store path takes it
               if (!save_valid_q || save_fire) begin
                  if (ff_any && !(save_fire && ff_idx == save_idx_q)) begin
                     save_valid_q <= 1'b1;
                     save_idx_q   <= ff_idx;
                     save_data_q  <= regs_q[ff_idx];
                  end else begin
                     save_valid_q <= 1'b0;
                     if (!ff_any || (save_fire && saved_q == (~(64'h1 << save_idx_q)))) begin
                        state_q <= gprf_pkg::GPRF_IDLE;
                     end
                  end
               end
            end
            default: begin
               state_q      <= gprf_pkg::GPRF_IDLE;
               save_valid_q <= 1'b0;
            end
         endcase
      end
   end

   // Issue outputs; saving never alters operand values
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         issue_stall_q  <= 1'b0;
         issue_accept_q <= 1'b0;
         opa_data_q     <= '0;
         opb_data_q     <= '0;
         copy_done_q    <= 1'b0;
         wb_stall_q     <= 1'b0;
         save_busy_q    <= 1'b0;
      end else begin
         issue_stall_q  <= stall;
         issue_accept_q <= accept;
         copy_done_q    <= accept && copy_zero;
         if (accept) begin
            opa_data_q <= rd(src1);
            opb_data_q <= is_copy ? '0 : rd(src2);
         end
         wb_stall_q  <= wb_valid && wb_idx != gprf_pkg::ZERO_IDX && wb_unsaved;
         save_busy_q <= (state_q == gprf_pkg::GPRF_SAVING) || ctx_switch;
      end
   end

   a_zero_never_written: assert property (@(posedge clock) disable iff (!rst_b)
      regs_q[0] == '0) else $error("register zero changed");
   a_copy_no_wait: assert property (@(posedge clock) disable iff (!rst_b)
      (issue_valid && copy_zero && !dst_unsaved && !dst_busy) |-> !stall)
      else $error("copy from zero stalled");
   a_stall_on_pending: assert property (@(posedge clock) disable iff (!rst_b)
      (issue_valid && !copy_zero && pending_q[src1]) |=> issue_stall_q)
      else $error("pending operand not stalled");
   a_wb_after_save: assert property (@(posedge clock) disable iff (!rst_b)
      wb_ok |-> (saved_q[wb_idx] || (save_fire && save_idx_q == wb_idx)))
      else $error("overwrite before save");
   sequence s_switch;
      ctx_switch ##1 !ctx_switch;
   endsequence
   a_switch_starts_save: assert property (@(posedge clock) disable iff (!rst_b)
      s_switch |-> state_q == gprf_pkg::GPRF_SAVING)
      else $error("save did not start");
   a_save_first_idx: assert property (@(posedge clock) disable iff (!rst_b)
      (save_valid_q && !$past(save_valid_q))
      |-> (save_idx_q == $past(ff_idx) && !saved_q[save_idx_q]))
      else $error("saved register offered");
   a_issue_unsaved: assert property (@(posedge clock) disable iff (!rst_b)
      accept |-> (dst == gprf_pkg::ZERO_IDX || saved_q[dst] || save_fire))
      else $error("issue to unsaved dest");
   a_zero_operand: assert property (@(posedge clock) disable iff (!rst_b)
      (accept && src1 == gprf_pkg::ZERO_IDX) |=> opa_data_q == '0)
      else $error("zero read nonzero");
endmodule

// ---- sim/gprf_store_model.sv ----
// Store path model that takes save offers promptly or every third cycle
`timescale 1ns/1ps
module gprf_store_model (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic slow,
   output logic      store_ready
);
   logic [1:0] gap_q;
   // Slow mode spreads a lazy save over many writes of the new code
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gap_q       <= 2'h0;
         store_ready <= 1'b0;
      end else begin
         gap_q       <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
         store_ready <= !slow || (gap_q == 2'h2);
      end
   end
endmodule

// ---- sim/gprf_regfile_tb_top.sv ----
// Self-checking bench for the register file with lazy context save
`timescale 1ns/1ps
module gprf_regfile_tb_top;
   logic        clock, rst_b, issue_valid, wb_valid, ctx_switch, slow, store_ready;
   logic        issue_stall_q, issue_accept_q, copy_done_q, wb_stall_q;
   logic        save_valid_q, save_busy_q;
   logic [31:0] issue_instr;
   logic [5:0]  wb_idx, save_idx_q;
   logic [63:0] wb_data, opa_data_q, opb_data_q, save_data_q;
   logic [63:0] sh [64];
   logic [127:0] op_q [$];
   logic [69:0] sv_q [$];
   int          mismatches, samples_checked, cyc, last_saved, n, m;

   gprf_regfile dut_u (.clock(clock), .rst_b(rst_b), .issue_valid(issue_valid),
      .issue_instr(issue_instr), .issue_stall_q(issue_stall_q),
      .issue_accept_q(issue_accept_q), .opa_data_q(opa_data_q), .opb_data_q(opb_data_q),
      .copy_done_q(copy_done_q), .wb_valid(wb_valid), .wb_idx(wb_idx), .wb_data(wb_data),
      .wb_stall_q(wb_stall_q), .ctx_switch(ctx_switch), .store_ready(store_ready),
      .save_valid_q(save_valid_q), .save_idx_q(save_idx_q), .save_data_q(save_data_q),
      .save_busy_q(save_busy_q));
   gprf_store_model model_u (.clock(clock), .rst_b(rst_b), .slow(slow),
      .store_ready(store_ready));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic issue(input logic [7:0] opc, input logic [5:0] d, s1, s2, output int k);
      @(posedge clock);
      #1 issue_instr = {opc, 6'h00, s2, s1, d};
      issue_valid = 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         #1 k++;
      end while (issue_accept_q !== 1'b1 && k < 300);
      issue_valid = 1'b0;
      op_q.push_back({sh[s1], (opc == gprf_pkg::OPC_COPY) ? 64'h0 : sh[s2]});
      check("copy done", opc == gprf_pkg::OPC_COPY && s1 == 6'h00, copy_done_q);
      if (opc == gprf_pkg::OPC_COPY && s1 == 6'h00) sh[d] = 64'h0;
   endtask

   // Shadow updated first so a stalled read never races the note
   task automatic wb(input logic [5:0] i, input logic [63:0] v, output int k);
      if (i != 6'h00) sh[i] = v;
      @(posedge clock);
      #1 wb_valid = 1'b1;
      wb_idx = i;
      wb_data = v;
      k = 0;
      do begin
         @(posedge clock);
         #1 k++;
      end while (wb_stall_q !== 1'b0 && k < 500);
      wb_valid = 1'b0;
   endtask

   always @(negedge clock) begin
      if (issue_accept_q === 1'b1) begin
         check("operands", op_q.pop_front(), {opa_data_q, opb_data_q});
      end
      if (save_valid_q === 1'b1 && store_ready === 1'b1) begin
         last_saved = save_idx_q;
         check("save offer", sv_q.pop_front(), {save_idx_q, save_data_q});
      end
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      {issue_valid, issue_instr, wb_valid, wb_idx, wb_data, ctx_switch, slow} = '0;
      rst_b = 1'b0;
      foreach (sh[i]) sh[i] = 64'h0;
      void'($urandom(32'hb0797e64));
      repeat (12) @(posedge clock);
      #1 rst_b = 1'b1;
      for (int r = 0; r < 64; r++) wb(6'(r), {$urandom, $urandom}, n);
      for (int r = 0; r < 64; r++) issue(8'h02, 6'h00, 6'(r), 6'(63 - r), n);
      // Copy from a live register passes the value and is no clear
      issue(gprf_pkg::OPC_COPY, 6'h00, 6'd5, 6'd6, n);
      $display("test register access done");
      issue(8'h02, 6'd7, 6'd3, 6'd4, n);
      issue(gprf_pkg::OPC_COPY, 6'd9, 6'd0, 6'd7, n);
      check("copy wait", 1, n);
      fork
         issue(8'h02, 6'h00, 6'd7, 6'd9, n);
         begin
            repeat (3) @(posedge clock);
            #1 check("operand stall", 1, issue_stall_q);
            wb(6'd7, {$urandom, $urandom}, m);
         end
      join
      $display("test scoreboard done");
      for (int s = 1; s >= 0; s--) begin
         slow = s[0];
         for (int r = 1; r < 64; r++) sv_q.push_back({6'(r), sh[r]});
         last_saved = 0;
         @(posedge clock);
         #1 ctx_switch = 1'b1;
         @(posedge clock);
         #1 ctx_switch = 1'b0;
         wb(6'd40, {$urandom, $urandom}, n);
         check("write stalled", 1, n > 1);
         check("saved before write", 1, last_saved >= 40);
         issue(8'h02, 6'h00, 6'd40, 6'd1, n);
         n = 0;
         while (save_busy_q !== 1'b0 && n < 400) begin
            @(posedge clock);
            #1 n++;
         end
         check("save busy", 0, save_busy_q);
         check("saves left", 0, sv_q.size());
         $display("test lazy save slow=%0d done", s);
      end
      print_verdict();
   end
endmodule
